// ===== verilog/rcwd_pkg.sv
// Purpose: Constants shared by the carrier wake detector files.
// Assumes: core_clk is the reference oscillator of the receiver.
// Notes: Constant list follows.
package rcwd_pkg;
    // ==========================================================
    // Timing
    localparam int SYS_DIV = 256;         // Reference cycles per tick
    localparam int QUAL_COUNT = 128;      // Ticks of steady carrier
    localparam int DIV_W = 8;             // Divider width
    localparam int QCNT_W = 8;            // Qualification counter width
    // ==========================================================
    // Reset values
    localparam logic RST_STANDBY = 1'h1;  // Standby after reset
    localparam logic RST_WAKE_N = 1'h1;   // Wake inactive after reset
    localparam logic RST_CARRIER = 1'h0;  // No carrier after reset
endpackage

// ===== verilog/rcwd_tick_if.sv
// Purpose: Carries the system tick and halt between the two modules.
// Assumes: Single core_clk domain.
// Notes: The top drives halt, the divider drives tick.
interface rcwd_tick_if;
    logic halt; // Hold divider at zero
    logic tick; // One-cycle system clock pulse
    modport top (output halt, input tick);
    modport div (input halt, output tick);
endinterface

// ===== verilog/rcwd_sys_divider.sv
// Purpose: Derives the system-clock tick from the reference clock.
// Assumes: halt comes from logic on the same clock.
// Notes: Divider restarts from zero whenever halt is released.
module rcwd_sys_divider #(
    parameter int DIV = rcwd_pkg::SYS_DIV
) (
    input wire logic core_clk,     // Reference clock
    input wire logic rst_b,        // Asynchronous reset, active low
    rcwd_tick_if.div tk            // Tick and halt
);
    import rcwd_pkg::*;

    localparam logic [DIV_W-1:0] LAST = DIV_W'(DIV - 1);

    logic [DIV_W-1:0] div_cnt;

    // ==========================================================
    // Divide by 256 into a one-cycle tick
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= '0;
            tk.tick <= 1'h0;
        end else if (tk.halt) begin
            div_cnt <= '0;
            tk.tick <= 1'h0;
        end else begin
            div_cnt <= div_cnt + 1'h1;
            tk.tick <= (div_cnt == LAST);
        end
    end

    // ==========================================================
    // Checks
    chk_tick_spacing: assert property (@(posedge core_clk) disable iff (!rst_b)
        tk.tick |-> ##1 (!tk.tick) [*8])
        else $error("tick repeated too soon");
    chk_tick_period: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!tk.halt && div_cnt == LAST) |=> tk.tick)
        else $error("tick missing at divider wrap");
    chk_halt_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
        tk.halt |=> (!tk.tick && div_cnt == '0))
        else $error("divider ran while halted");
endmodule

// ===== verilog/rf_carrier_wake_detector.sv
// Purpose: Qualifies a steady RF carrier and drives the wake flag.
// Assumes: Both inputs are asynchronous pins; core_clk is the reference.
// Notes: Wake flag comes straight from a flop and idles high.
//   Timing from the pins, in core_clk cycles:
//   - Each pin passes two flops, so logic sees it two cycles late.
//   - The divider starts when synchronised standby falls; its first
//     tick comes one full divide period later, then once a period.
//   - The first tick with carrier seen only loads the sampled carrier;
//     each later tick with carrier still seen adds one to the count.
//   - Wake falls one cycle after the count reaches its terminal value,
//     one tick more than the qualification length after carrier rises.
//   - A carrier gap shorter than one tick period can slip past unseen;
//     a gap seen at a tick clears the count and releases wake.
//   - Standby clears sampled carrier, count and wake together, so a
//     new enable always starts a full qualification.
//   - Reset puts the block in standby until the pin reads low, which
//     stands in for the pull-up on the standby pin.
module rf_carrier_wake_detector (
    input wire logic core_clk,             // Reference oscillator clock
    input wire logic rst_b,                // Asynchronous reset, active low
    input wire logic standby_select_level, // High selects standby
    input wire logic carrier_present,      // Front end sees carrier
    output logic carrier_wake_n            // Low while carrier qualified
);
    import rcwd_pkg::*;

    localparam logic [QCNT_W-1:0] QUAL = QCNT_W'(QUAL_COUNT);

    logic standby_m;
    logic standby_s;
    logic carrier_m;
    logic carrier_s;
    logic carrier_sys;
    logic [QCNT_W-1:0] qual_count;
    logic next_wake_n;

    rcwd_tick_if tk ();

    // ==========================================================
    // Pin synchronisers; standby comes up asserted
    // The first flop may go metastable; only the second one is read
    // Standby resets to one, standing in for the pull-up on the pin
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            standby_m <= RST_STANDBY;
            standby_s <= RST_STANDBY;
        end else begin
            standby_m <= standby_select_level;
            standby_s <= standby_m;
        end
    end

    // Carrier pin passes the same two stages
    // No carrier is assumed until the pin has been seen twice
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            carrier_m <= RST_CARRIER;
            carrier_s <= RST_CARRIER;
        end else begin
            carrier_m <= carrier_present;
            carrier_s <= carrier_m;
        end
    end

    // Standby halts the system clock
    // Divider restarts from zero on each enable, so tick phase is fixed
    assign tk.halt = standby_s;

    rcwd_sys_divider #(
        .DIV(SYS_DIV)
    ) u_div (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .tk(tk)
    );

    // ==========================================================
    // Carrier sampled on the system tick
    // Holding the sample between ticks keeps the count in tick units;
    // the price is that a gap between two ticks is never seen
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            carrier_sys <= RST_CARRIER;
        end else if (standby_s) begin
            carrier_sys <= RST_CARRIER;
        end else if (tk.tick) begin
            carrier_sys <= carrier_s;
        end
    end

    // ==========================================================
    // Qualification counter, cleared on loss, held at terminal
    // Saturating keeps a long carrier from wrapping into a false restart
    // Clearing on the sampled carrier restarts qualification at once
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            qual_count <= '0;
        end else if (standby_s || !carrier_sys) begin
            qual_count <= '0;
        end else if (tk.tick && qual_count != QUAL) begin
            qual_count <= qual_count + 1'h1;
        end
    end

    // ==========================================================
    // Wake flag, low while qualified carrier persists
    // Registered so the pin never glitches while the count settles
    always_comb begin
        next_wake_n = 1'h1;
        if (!standby_s && carrier_sys && qual_count == QUAL) begin
            next_wake_n = 1'h0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            carrier_wake_n <= RST_WAKE_N;
        end else if (standby_s) begin
            carrier_wake_n <= 1'h1;
        end else begin
            carrier_wake_n <= next_wake_n;
        end
    end

    // ==========================================================
    // Checks
    chk_standby_wake_high: assert property (@(posedge core_clk)
        disable iff (!rst_b) standby_s |=> carrier_wake_n)
        else $error("wake asserted in standby");
    chk_standby_count_zero: assert property (@(posedge core_clk)
        disable iff (!rst_b) standby_s |=> qual_count == '0)
        else $error("counter ran in standby");
    chk_wake_needs_qual: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        !carrier_wake_n |-> ($past(qual_count) == QUAL))
        else $error("wake without full qualification");
    chk_count_clears: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (tk.tick && !carrier_s && !standby_s) |=> ##1
        qual_count == '0)
        else $error("counter not cleared on carrier loss");
    chk_count_holds: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        qual_count == QUAL |=> (qual_count == QUAL || qual_count == '0))
        else $error("counter left terminal value");
    chk_count_steps: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (qual_count != QUAL && !tk.tick && carrier_sys && !standby_s)
        |=> $stable(qual_count))
        else $error("counter moved without tick");
    chk_wake_asserts: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (qual_count == QUAL && carrier_sys && !standby_s)
        |=> !carrier_wake_n)
        else $error("wake not asserted after qualification");
    chk_wake_release: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        $rose(carrier_wake_n) |-> $past(!carrier_sys || standby_s))
        else $error("wake released without cause");
    chk_wake_holds: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (!carrier_wake_n && carrier_sys && !standby_s)
        |=> !carrier_wake_n)
        else $error("wake pulse ended while carrier held");

    // ==========================================================
    // Synchroniser and sampling checks
    // Pins reach the logic only through both flops
    chk_sync_standby: assert property (@(posedge core_clk)
        disable iff (!rst_b) standby_s == $past(standby_m))
        else $error("standby synchroniser skipped a stage");
    chk_sync_carrier: assert property (@(posedge core_clk)
        disable iff (!rst_b) carrier_s == $past(carrier_m))
        else $error("carrier synchroniser skipped a stage");

    // Carrier is taken only at ticks and dropped in standby
    chk_sample_on_tick: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (tk.tick && !standby_s) |=> carrier_sys == $past(carrier_s))
        else $error("carrier not sampled at tick");
    chk_sample_holds: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (!tk.tick && !standby_s) |=> $stable(carrier_sys))
        else $error("carrier sample moved between ticks");
    chk_standby_clears: assert property (@(posedge core_clk)
        disable iff (!rst_b) standby_s |=> !carrier_sys)
        else $error("carrier sample kept in standby");

    // Count stays in range and rises only by one step at a tick
    chk_count_bounded: assert property (@(posedge core_clk)
        disable iff (!rst_b) qual_count <= QUAL)
        else $error("counter passed terminal value");
    chk_count_on_tick: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (qual_count != $past(qual_count) && qual_count != '0)
        |-> ($past(tk.tick) && qual_count == $past(qual_count) + 1'h1))
        else $error("counter stepped off a tick");

    // Wake needs carrier and enable, and drops on a seen loss
    chk_wake_needs_carrier: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        !carrier_wake_n |-> ($past(carrier_sys) && !$past(standby_s)))
        else $error("wake without carrier or in standby");
    chk_loss_release: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (!carrier_sys && !standby_s) |=> carrier_wake_n)
        else $error("wake kept after carrier loss");

    // Main scenarios: wake, release by loss or standby, partial restart,
    // and the count saturating while the carrier stays
    cov_wake_seen: cover property (@(posedge core_clk)
        disable iff (!rst_b) $fell(carrier_wake_n));
    cov_wake_by_loss: cover property (@(posedge core_clk)
        disable iff (!rst_b) $rose(carrier_wake_n) && !standby_s);
    cov_wake_by_standby: cover property (@(posedge core_clk)
        disable iff (!rst_b) $rose(carrier_wake_n) && standby_s);
    cov_partial_restart: cover property (@(posedge core_clk)
        disable iff (!rst_b)
        qual_count > '0 && qual_count < QUAL && !carrier_sys);
    cov_count_saturated: cover property (@(posedge core_clk)
        disable iff (!rst_b) qual_count == QUAL && tk.tick);
endmodule

// ===== testbench/rcwd_decoder_model.sv
// Purpose: Decoder that gates the receiver and counts its wake pulses.
// Assumes: Single core_clk domain; the bench asks for reception.
// Notes: A released standby pin floats high through the pull-up.
module rcwd_decoder_model (
    input wire logic core_clk,          // Reference clock
    input wire logic rst_b,             // Reset, active low
    input wire logic rx_enable,         // Bench asks for reception
    input wire logic carrier_wake_n,    // Wake flag from the receiver
    output logic standby_select_level,  // Standby pin level
    output int wake_pulses              // Wake assertions seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wake_last;
    // Pin pulled low only to enable reception, else the pull-up wins
    assign standby_select_level = rx_enable ? 1'h0 : 1'h1;
    // Counts each falling edge of the wake flag
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_last <= 1'h1;
            wake_pulses <= 0;
        end else begin
            wake_last <= carrier_wake_n;
            if (wake_last === 1'h1 && carrier_wake_n === 1'h0)
                wake_pulses <= wake_pulses + 1;
        end
    end
endmodule

// ===== testbench/test_rf_carrier_wake_detector.sv
// Purpose: Self-checking bench for the carrier wake detector.
// Assumes: 100 MHz core_clk; full tick divider of 256 cycles.
// Notes: Row checkpoints sit clear of the tick phase uncertainty.
module test_rf_carrier_wake_detector;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic standby;
        logic carrier;
        int cycles;
        logic wake_n;
    } rcwd_row_s;
    logic core_clk = 1'h0;
    logic rst_b = 1'h0;
    logic rx_enable = 1'h0;
    logic carrier_present = 1'h1;
    logic standby_select_level;
    logic carrier_wake_n;
    int wake_pulses;
    int failures = 0;
    int num_checks = 0;
    // Inputs held for a span, then the wake level expected
    rcwd_row_s rows [9] = '{
        '{1'h1, 1'h1, 2000, 1'h1}, '{1'h0, 1'h1, 32868, 1'h1},
        '{1'h0, 1'h1, 256, 1'h0}, '{1'h0, 1'h1, 2000, 1'h0},
        '{1'h0, 1'h0, 300, 1'h1}, '{1'h0, 1'h1, 32700, 1'h1},
        '{1'h0, 1'h1, 700, 1'h0}, '{1'h1, 1'h1, 5, 1'h1},
        '{1'h0, 1'h1, 300, 1'h1}};
    rf_carrier_wake_detector DUT (
        .core_clk(core_clk), .rst_b(rst_b),
        .standby_select_level(standby_select_level),
        .carrier_present(carrier_present), .carrier_wake_n(carrier_wake_n));
    rcwd_decoder_model far_end (
        .core_clk(core_clk), .rst_b(rst_b), .rx_enable(rx_enable),
        .carrier_wake_n(carrier_wake_n),
        .standby_select_level(standby_select_level),
        .wake_pulses(wake_pulses));
    // ==========================================================
    // Clock and helpers
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // Moves to just after a rising edge
    task step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task check(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask
    task conclude;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        step(1);
        check(carrier_wake_n, 1'h1, "wake low in reset");
        step(9);
        rst_b = 1'h1;
        for (int i = 0; i < 9; i++) begin
            rx_enable = !rows[i].standby;
            carrier_present = rows[i].carrier;
            step(rows[i].cycles);
            check(carrier_wake_n, rows[i].wake_n, "row wake level");
            $display("row %0d done", i);
        end
        check(wake_pulses == 2, 1'h1, "wake pulse count");
        $display("pulse count test done");
        // Mid-run reset with the pin low must restart qualification
        rst_b = 1'h0;
        step(1);
        check(carrier_wake_n, 1'h1, "wake low in reset");
        step(2);
        rst_b = 1'h1;
        step(1000);
        check(carrier_wake_n, 1'h1, "early wake after reset");
        $display("reset test done");
        conclude();
    end
    // Cuts a hang short after the expected run length
    initial begin
        #800000;
        failures++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
